// *** src/rxsp_consts.svh ***
// register indices, field positions, reset values and codes of the rx config bank
`ifndef RXSP_CONSTS_SVH
`define RXSP_CONSTS_SVH

`define RXSP_CM_IDX      8'h1B
`define RXSP_RM_IDX      8'h1C
`define RXSP_CTL_IDX     8'h20

`define RXSP_CM_RST      32'h0000_0000
`define RXSP_RM_RST      32'h0000_0000
`define RXSP_CTL_RST     32'h0000_0000

`define RXSP_FRM_MSB     30
`define RXSP_FRM_LSB     29
`define RXSP_TAP_MSB     28
`define RXSP_TAP_LSB     26
`define RXSP_ETH_MSB     25
`define RXSP_ETH_LSB     13
`define RXSP_BTH_MSB     12
`define RXSP_BTH_LSB     0
`define RXSP_IQ_MSB      23
`define RXSP_IQ_LSB      21
`define RXSP_AUTO_BIT    0
`define RXSP_SEEN_BIT    8

`define RXSP_FRM_TYPE_A  2'h0
`define RXSP_FRM_P2P     2'h1
`define RXSP_SYNC_BYTE   8'hF0

`define RXSP_IQ_BOTH     3'h0
`define RXSP_IQ_ONLY_I   3'h1
`define RXSP_IQ_ONLY_Q   3'h2
`define RXSP_IQ_STRONG   3'h4
`define RXSP_IQ_FIRST    3'h5

`define RXSP_TAPS_0      6'h04
`define RXSP_TAPS_1      6'h06
`define RXSP_TAPS_2      6'h08
`define RXSP_TAPS_3      6'h08
`define RXSP_TAPS_4      6'h10
`define RXSP_TAPS_5      6'h12
`define RXSP_TAPS_6      6'h18
`define RXSP_TAPS_7      6'h20

`endif

// *** src/rxsp_pkg.sv ***
// types and shared decode of the rx signal-processing config bank
`include "rxsp_consts.svh"
package rxsp_pkg;

    typedef struct packed {
        logic        rsvd;
        logic [1:0]  framing;
        logic [2:0]  tap_sel;
        logic [12:0] edge_th;
        logic [12:0] bit_th;
    } rxsp_cm_cfg_t;

    typedef struct packed {
        logic        wr;
        logic [7:0]  idx;
        logic        addr_ok;
        logic [31:0] wdata;
    } rxsp_reg_acc_t;

    function automatic logic [5:0] rxsp_tap_count(input logic [2:0] sel);
        logic [5:0] n;
        n = `RXSP_TAPS_0;
        unique case (sel)
            3'h0: n = `RXSP_TAPS_0;
            3'h1: n = `RXSP_TAPS_1;
            3'h2: n = `RXSP_TAPS_2;
            3'h3: n = `RXSP_TAPS_3;
            3'h4: n = `RXSP_TAPS_4;
            3'h5: n = `RXSP_TAPS_5;
            3'h6: n = `RXSP_TAPS_6;
            3'h7: n = `RXSP_TAPS_7;
        endcase
        return n;
    endfunction

endpackage

// *** src/rxsp_apb_slave.sv ***
// apb slave front end with one wait state and registered answer
`timescale 1ns/1ps
`include "rxsp_consts.svh"
module rxsp_apb_slave
    import rxsp_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,     // bus clock
    input  wire logic              presetn,  // async reset, active low
    input  wire logic              psel,     // slave select
    input  wire logic              penable,  // access phase
    input  wire logic              pwrite,   // 1 = write
    input  wire logic [ADDR_W-1:0] paddr,    // byte address
    input  wire logic [31:0]       pwdata,   // write data
    input  wire logic [31:0]       rd_data,  // read data of decoded index
    input  wire logic              mapped,   // index names a register
    output logic                   pready,   // answer strobe
    output logic [31:0]            prdata,   // read data
    output logic                   pslverr,  // unmapped or misaligned
    output rxsp_reg_acc_t          acc       // write strobe to the bank
);

    generate
        if (ADDR_W < 11) begin : g_bad_addr
            $error("rxsp_apb_slave: ADDR_W must be at least 11");
        end
    endgenerate

    wire logic        addr_ok;
    wire logic        ok;
    wire logic        next_pready;
    wire logic [31:0] next_prdata;
    wire logic        next_pslverr;

    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    assign ok      = addr_ok && mapped;

    // the wait state lets the answer come from flops, not from the decoder
    assign next_pready  = psel && penable && !pready;
    assign next_prdata  = (next_pready && !pwrite && ok) ? rd_data : 32'h0;
    assign next_pslverr = next_pready && !ok;

    assign acc = '{wr:      psel && penable && pready && pwrite && !pslverr,
                   idx:     paddr[9:2],
                   addr_ok: addr_ok,
                   wdata:   pwdata};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule

// *** src/rxsp_chan_sel.sv ***
// i/q channel choice for the phase-shift demodulator
`timescale 1ns/1ps
`include "rxsp_consts.svh"
module rxsp_chan_sel
    import rxsp_pkg::*;
#(
    parameter int MAG_W = 12
) (
    input  wire logic             pclk,        // clock
    input  wire logic             presetn,     // async reset, active low
    input  wire logic [2:0]       mode,        // channel-mode code
    input  wire logic [MAG_W-1:0] i_mag,       // i channel strength
    input  wire logic [MAG_W-1:0] q_mag,       // q channel strength
    input  wire logic             i_act,       // i channel signal seen
    input  wire logic             q_act,       // q channel signal seen
    input  wire logic             frame_start, // new frame, forget arrival
    output logic                  use_i,       // process i channel
    output logic                  use_q        // process q channel
);

    generate
        if (MAG_W < 1) begin : g_bad_mag
            $error("rxsp_chan_sel: MAG_W must be at least 1");
        end
    endgenerate

    logic        got_i;
    logic        got_q;
    wire logic   none_yet;
    wire logic   next_got_i;
    wire logic   next_got_q;
    wire logic   i_strong;
    wire logic   first_i;
    wire logic   first_q;
    logic        next_use_i;
    logic        next_use_q;

    // arrival race: i wins a tie in the same cycle
    assign none_yet   = !got_i && !got_q;
    assign next_got_i = !frame_start && (got_i || (none_yet && i_act));
    assign next_got_q = !frame_start &&
                        (got_q || (none_yet && !i_act && q_act));
    assign i_strong   = (i_mag >= q_mag);
    // until one channel has arrived both stay in use
    assign first_i    = got_i || none_yet;
    assign first_q    = got_q || none_yet;

    always_comb begin
        next_use_i = 1'b1;
        next_use_q = 1'b1;
        unique case (mode)
            `RXSP_IQ_BOTH: begin
                next_use_i = 1'b1;
                next_use_q = 1'b1;
            end
            `RXSP_IQ_ONLY_I: begin
                next_use_i = 1'b1;
                next_use_q = 1'b0;
            end
            `RXSP_IQ_ONLY_Q: begin
                next_use_i = 1'b0;
                next_use_q = 1'b1;
            end
            `RXSP_IQ_STRONG: begin
                next_use_i = i_strong;
                next_use_q = !i_strong;
            end
            `RXSP_IQ_FIRST: begin
                next_use_i = first_i;
                next_use_q = first_q;
            end
            default: begin
                next_use_i = 1'b1;
                next_use_q = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got_i <= 1'b0;
            got_q <= 1'b0;
            use_i <= 1'b1;
            use_q <= 1'b1;
        end else begin
            got_i <= next_got_i;
            got_q <= next_got_q;
            use_i <= next_use_i;
            use_q <= next_use_q;
        end
    end

endmodule

// *** src/rxsp_regs.sv ***
// rx signal-processing configuration bank with apb access
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "rxsp_consts.svh"
// Functional notes
// - card bits 30:29 pick framing, 00 type A, 01 peer-to-peer with sync F0h.
// - with auto detection on, a detected mode overwrites the framing field.
// - card bits 28:26 give 4, 6, 8, 8, 16, 18, 24 or 32 edge filter taps.
// - the edge decision threshold is bits 25:13 of the card-mode word.
// - the bit decision threshold is bits 12:0 of the card-mode word.
// - reader bits 23:21 pick channels, 000 both at reset, 001 I, 010 Q.
// - code 100 takes the stronger channel, 101 the one that arrives first.
module rxsp_regs
    import rxsp_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int MAG_W  = 12
) (
    input  wire logic              pclk,           // 100 MHz bus clock
    input  wire logic              presetn,        // async reset, active low
    input  wire logic              psel,           // apb select
    input  wire logic              penable,        // apb access phase
    input  wire logic              pwrite,         // apb direction
    input  wire logic [ADDR_W-1:0] paddr,          // apb byte address
    input  wire logic [31:0]       pwdata,         // apb write data
    output logic                   pready,         // apb ready
    output logic [31:0]            prdata,         // apb read data
    output logic                   pslverr,        // apb error
    input  wire logic              md_valid,       // mode detector result
    input  wire logic [1:0]        md_framing,     // detected framing
    input  wire logic [MAG_W-1:0]  i_mag,          // i channel strength
    input  wire logic [MAG_W-1:0]  q_mag,          // q channel strength
    input  wire logic              i_act,          // i channel activity
    input  wire logic              q_act,          // q channel activity
    input  wire logic              frame_start,    // frame begins
    output logic [1:0]             rx_framing,     // framing to demod
    output logic [7:0]             sync_byte,      // expected sync byte
    output logic [5:0]             edge_taps,      // edge filter length
    output logic [12:0]            edge_threshold, // edge decision level
    output logic [12:0]            bit_threshold,  // bit decision level
    output logic                   use_i,          // demod uses i
    output logic                   use_q           // demod uses q
);

    rxsp_reg_acc_t acc;
    rxsp_cm_cfg_t  cm_cfg;
    logic [2:0]    iq_mode;
    logic          auto_en;
    logic          md_seen;
    logic [1:0]    md_last;

    wire logic        hit_cm;
    wire logic        hit_rm;
    wire logic        hit_ctl;
    wire logic        mapped;
    wire logic        cm_wr;
    wire logic        rm_wr;
    wire logic        ctl_wr;
    wire logic        md_take;
    wire logic [31:0] rd_data;
    wire logic [31:0] cm_rd;
    wire logic [31:0] rm_rd;
    wire logic [31:0] ctl_rd;
    wire logic [2:0]  eff_mode;
    wire logic        iq_reserved;
    wire logic [1:0]  next_framing;
    wire logic [2:0]  next_tap_sel;
    wire logic [12:0] next_edge_th;
    wire logic [12:0] next_bit_th;
    wire logic [2:0]  next_iq_mode;
    wire logic        next_auto_en;
    wire logic        next_md_seen;
    wire logic [1:0]  next_md_last;
    wire logic [7:0]  next_sync_byte;

    rxsp_apb_slave #(
        .ADDR_W (ADDR_W)
    ) u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .rd_data (rd_data),
        .mapped  (mapped),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .acc     (acc)
    );

    assign hit_cm  = (acc.idx == `RXSP_CM_IDX);
    assign hit_rm  = (acc.idx == `RXSP_RM_IDX);
    assign hit_ctl = (acc.idx == `RXSP_CTL_IDX);
    assign mapped  = hit_cm || hit_rm || hit_ctl;
    assign cm_wr   = acc.wr && hit_cm;
    assign rm_wr   = acc.wr && hit_rm;
    assign ctl_wr  = acc.wr && hit_ctl;

    // the detector is the later writer, so it overrides a same-cycle write
    assign md_take = md_valid && auto_en;
    assign next_framing = md_take ? md_framing :
                          cm_wr ? acc.wdata[`RXSP_FRM_MSB:`RXSP_FRM_LSB] :
                          cm_cfg.framing;
    assign next_tap_sel = cm_wr ? acc.wdata[`RXSP_TAP_MSB:`RXSP_TAP_LSB]
                                : cm_cfg.tap_sel;
    assign next_edge_th = cm_wr ? acc.wdata[`RXSP_ETH_MSB:`RXSP_ETH_LSB]
                                : cm_cfg.edge_th;
    assign next_bit_th  = cm_wr ? acc.wdata[`RXSP_BTH_MSB:`RXSP_BTH_LSB]
                                : cm_cfg.bit_th;
    assign next_iq_mode = rm_wr ? acc.wdata[`RXSP_IQ_MSB:`RXSP_IQ_LSB]
                                : iq_mode;
    assign next_auto_en = ctl_wr ? acc.wdata[`RXSP_AUTO_BIT] : auto_en;
    // sticky detect flag: a detection in the clearing cycle survives
    assign next_md_seen = md_take ||
                          (md_seen && !(ctl_wr && acc.wdata[`RXSP_SEEN_BIT]));
    assign next_md_last = md_take ? md_framing : md_last;

    // reserved codes are kept as written but steer nothing
    assign iq_reserved = (iq_mode != `RXSP_IQ_BOTH) &&
                         (iq_mode != `RXSP_IQ_ONLY_I) &&
                         (iq_mode != `RXSP_IQ_ONLY_Q) &&
                         (iq_mode != `RXSP_IQ_STRONG) &&
                         (iq_mode != `RXSP_IQ_FIRST);
    assign eff_mode = iq_reserved ? `RXSP_IQ_BOTH : iq_mode;

    // only peer-to-peer framing expects a sync byte
    assign next_sync_byte = (cm_cfg.framing == `RXSP_FRM_P2P) ?
                            `RXSP_SYNC_BYTE : 8'h00;

    // bit 31 and the unused fields read as zero
    assign cm_rd  = {1'b0, cm_cfg.framing, cm_cfg.tap_sel,
                     cm_cfg.edge_th, cm_cfg.bit_th};
    assign rm_rd  = {8'h00, iq_mode, 21'h000000};
    // ctl: 0 auto, 8 seen, 10:9 last framing, 12 use_i, 13 use_q
    assign ctl_rd = {18'h00000, use_q, use_i, 1'b0, md_last, md_seen,
                     7'h00, auto_en};
    assign rd_data = hit_cm ? cm_rd : hit_rm ? rm_rd :
                     hit_ctl ? ctl_rd : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cm_cfg  <= `RXSP_CM_RST;
            iq_mode <= 3'(`RXSP_RM_RST >> `RXSP_IQ_LSB);
            auto_en <= 1'b0;
            md_seen <= 1'b0;
            md_last <= `RXSP_FRM_TYPE_A;
        end else begin
            cm_cfg  <= '{rsvd: 1'b0, framing: next_framing,
                         tap_sel: next_tap_sel, edge_th: next_edge_th,
                         bit_th: next_bit_th};
            iq_mode <= next_iq_mode;
            auto_en <= next_auto_en;
            md_seen <= next_md_seen;
            md_last <= next_md_last;
        end
    end

    // outputs are re-timed copies so the demodulator sees clean flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_framing     <= `RXSP_FRM_TYPE_A;
            sync_byte      <= 8'h00;
            edge_taps      <= `RXSP_TAPS_0;
            edge_threshold <= 13'h0000;
            bit_threshold  <= 13'h0000;
        end else begin
            rx_framing     <= cm_cfg.framing;
            sync_byte      <= next_sync_byte;
            edge_taps      <= rxsp_tap_count(cm_cfg.tap_sel);
            edge_threshold <= cm_cfg.edge_th;
            bit_threshold  <= cm_cfg.bit_th;
        end
    end

    rxsp_chan_sel #(
        .MAG_W (MAG_W)
    ) u_chan (
        .pclk        (pclk),
        .presetn     (presetn),
        .mode        (eff_mode),
        .i_mag       (i_mag),
        .q_mag       (q_mag),
        .i_act       (i_act),
        .q_act       (q_act),
        .frame_start (frame_start),
        .use_i       (use_i),
        .use_q       (use_q)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_detect_overrides: assert property (
        md_valid && auto_en |=> cm_cfg.framing == $past(md_framing) ##1
            rx_framing == $past(md_framing, 2))
        else $error("detected framing not taken over");

    a_framing_write: assert property (
        cm_wr && !md_take |=> ##1
            rx_framing == $past(pwdata[30:29], 2))
        else $error("framing write did not reach output");

    a_sync_byte: assert property (
        cm_cfg.framing == `RXSP_FRM_P2P |=> sync_byte == 8'hF0)
        else $error("sync byte wrong for peer framing");

    a_tap_count: assert property (
        cm_wr && pwdata[28:26] == 3'h5 |=> ##1 edge_taps == 6'h12)
        else $error("edge filter taps mismatch");

    a_tap_dup_code: assert property (
        cm_cfg.tap_sel == 3'h3 |=> edge_taps == 6'h08)
        else $error("code 3 must give 8 taps");

    a_edge_thresh: assert property (
        cm_wr |=> ##1 edge_threshold == $past(pwdata[25:13], 2))
        else $error("edge threshold not from bits 25:13");

    a_bit_thresh: assert property (
        cm_wr |=> ##1 bit_threshold == $past(pwdata[12:0], 2))
        else $error("bit threshold not from bits 12:0");

    a_only_i_chan: assert property (
        iq_mode == 3'h1 |=> use_i && !use_q)
        else $error("only-i mode drives wrong channels");

    a_only_q_chan: assert property (
        iq_mode == 3'h2 |=> !use_i && use_q)
        else $error("only-q mode drives wrong channels");

    a_strong_chan: assert property (
        iq_mode == 3'h4 && q_mag > i_mag |=> !use_i && use_q)
        else $error("stronger channel not chosen");

    a_first_chan: assert property (
        iq_mode == 3'h5 && !frame_start && !i_act && q_act &&
        !$past(i_act) && $past(frame_start) ##1 iq_mode == 3'h5 &&
        !frame_start |=> !use_i && use_q)
        else $error("first arriving channel not chosen");

    a_reserved_dual: assert property (
        iq_mode == 3'h3 || iq_mode == 3'h6 || iq_mode == 3'h7
            |=> use_i && use_q)
        else $error("reserved channel code not dual");

    a_apb_answer: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not a single cycle pulse");

    a_detect_ignored: assert property (
        md_valid && !auto_en && !cm_wr
            |=> cm_cfg.framing == $past(cm_cfg.framing))
        else $error("detection taken while auto detection off");

    a_detect_wins: assert property (
        md_take && cm_wr |=> cm_cfg.framing == $past(md_framing))
        else $error("software write beat the mode detector");

    // the sticky flag must survive a clear that meets a detection
    a_seen_sticky: assert property (
        md_take |=> md_seen)
        else $error("detection seen flag not set");

    a_seen_clear: assert property (
        ctl_wr && pwdata[8] && !md_take |=> !md_seen)
        else $error("detection seen flag not cleared");

    a_refused_write: assert property (
        psel && penable && pready && pslverr && !md_take
            |=> $stable(cm_cfg) && $stable(iq_mode) && $stable(auto_en))
        else $error("refused write changed a register");

    a_read_zero: assert property (
        pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");

    a_sync_off: assert property (
        cm_cfg.framing == `RXSP_FRM_TYPE_A |=> sync_byte == 8'h00)
        else $error("sync byte set for type A framing");

    a_tap_smallest: assert property (
        cm_cfg.tap_sel == 3'h0 |=> edge_taps == 6'h04)
        else $error("code 0 must give 4 taps");

    a_tap_largest: assert property (
        cm_cfg.tap_sel == 3'h7 |=> edge_taps == 6'h20)
        else $error("code 7 must give 32 taps");

    a_both_chan: assert property (
        iq_mode == 3'h0 |=> use_i && use_q)
        else $error("dual mode drives wrong channels");

    a_strong_tie: assert property (
        iq_mode == 3'h4 && i_mag >= q_mag |=> use_i && !use_q)
        else $error("i channel must win a strength tie");

    c_p2p_write: cover property (
        cm_wr && pwdata[30:29] == 2'h1 ##2 sync_byte == 8'hF0);
    c_detect_win: cover property (md_take && cm_wr);
    c_strong_mode: cover property (iq_mode == 3'h4 ##1 use_q && !use_i);
    c_unmapped: cover property (pready && pslverr);
    c_first_chan: cover property (iq_mode == 3'h5 ##1 !use_i && use_q);

endmodule

// *** verif/rxsp_regs_bench.sv ***
// self-checking bench for the rx signal-processing config bank
`timescale 1ns/1ps
module rxsp_regs_bench;
    import rxsp_pkg::*;
    localparam logic [11:0] CM_A = 12'h06C;
    localparam logic [11:0] RM_A = 12'h070;
    localparam logic [11:0] CT_A = 12'h080;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr, i_mag, q_mag;
    logic [31:0] pwdata, prdata, rd, wd;
    logic        pready, pslverr, er, md_valid;
    logic        i_act, q_act, frame_start, use_i, use_q;
    logic [1:0]  md_framing, rx_framing;
    logic [7:0]  sync_byte;
    logic [5:0]  edge_taps;
    logic [12:0] edge_threshold, bit_threshold;
    int          errors, check_count;
    logic [5:0]  taps [8] = '{6'h04, 6'h06, 6'h08, 6'h08,
                              6'h10, 6'h12, 6'h18, 6'h20};
    // expected {use_i, use_q} per code with q the stronger, no activity
    logic [1:0]  use_exp [8] = '{2'b11, 2'b10, 2'b01, 2'b11,
                                 2'b01, 2'b11, 2'b11, 2'b11};

    rxsp_regs dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .md_valid(md_valid), .md_framing(md_framing),
        .i_mag(i_mag), .q_mag(q_mag), .i_act(i_act), .q_act(q_act),
        .frame_start(frame_start), .rx_framing(rx_framing),
        .sync_byte(sync_byte), .edge_taps(edge_taps),
        .edge_threshold(edge_threshold), .bit_threshold(bit_threshold),
        .use_i(use_i), .use_q(use_q)
    );

    always #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; the watchdog ends a wait that never sees pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look just after each edge, once the slave's flops have settled
        do begin
            @(posedge pclk);
            #1;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        // the edge after pready is seen high is the one that commits
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic pulse_md(input logic [1:0] f);
        @(posedge pclk);
        md_valid <= 1'b1;
        md_framing <= f;
        @(posedge pclk);
        md_valid <= 1'b0;
    endtask

    // frame start in one cycle, channel activity in the next
    task automatic pulse_act(input logic fs, input logic ia, input logic qa);
        @(posedge pclk);
        frame_start <= fs;
        @(posedge pclk);
        frame_start <= 1'b0;
        i_act <= ia;
        q_act <= qa;
        @(posedge pclk);
        i_act <= 1'b0;
        q_act <= 1'b0;
    endtask

    task automatic complete_run;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        complete_run;
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, md_valid, i_act, q_act, frame_start} = '0;
        paddr = '0;
        pwdata = '0;
        md_framing = 2'h0;
        i_mag = 12'h003;
        q_mag = 12'h009;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        settle;
        chk(edge_taps, 6'h04);
        chk({use_i, use_q}, 2'b11);
        chk(sync_byte, 8'h00);
        apb(1'b0, RM_A, 32'h0);
        chk(rd, 32'h0);
        // framing, taps and both thresholds for every tap code
        for (int i = 0; i < 8; i++) begin
            wd = {2'b10, i[0], i[2:0], i[2:0], 10'h2AA, 10'h155, i[2:0]};
            apb(1'b1, CM_A, wd);
            settle;
            chk(rx_framing, {1'b0, i[0]});
            chk(sync_byte, i[0] ? 8'hF0 : 8'h00);
            chk(edge_taps, taps[i]);
            chk(edge_threshold, wd[25:13]);
            chk(bit_threshold, wd[12:0]);
            apb(1'b0, CM_A, 32'h0);
            chk(rd, wd & 32'h7FFF_FFFF);
        end
        // detector ignored while auto is off, then overrides software
        apb(1'b1, CM_A, 32'h0000_1FFF);
        pulse_md(2'h1);
        settle;
        chk(rx_framing, 2'h0);
        apb(1'b1, CT_A, 32'h1);
        pulse_md(2'h1);
        settle;
        chk(rx_framing, 2'h1);
        chk(sync_byte, 8'hF0);
        apb(1'b0, CM_A, 32'h0);
        chk(rd, 32'h2000_1FFF);
        apb(1'b0, CT_A, 32'h0);
        chk(rd[8], 1'b1);
        chk(rd[10:9], 2'h1);
        // writing 1 to the seen flag clears it, auto stays on
        apb(1'b1, CT_A, 32'h0000_0101);
        apb(1'b0, CT_A, 32'h0);
        chk(rd[8], 1'b0);
        chk(rd[0], 1'b1);
        // unmapped and misaligned places are refused
        apb(1'b0, 12'h084, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h06D, 32'h0);
        chk(er, 1'b1);
        apb(1'b0, CM_A, 32'h0);
        chk(rd, 32'h2000_1FFF);
        // every channel-mode code, reserved ones included
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, RM_A, {8'hFF, c[2:0], 21'h1F_FFFF});
            settle;
            chk({use_i, use_q}, use_exp[c]);
            apb(1'b0, RM_A, 32'h0);
            chk(rd, {8'h00, c[2:0], 21'h0});
        end
        // strongest with equal strength: i wins the tie
        apb(1'b1, RM_A, 32'h0080_0000);
        i_mag <= 12'h009;
        settle;
        chk({use_i, use_q}, 2'b10);
        @(posedge pclk);
        i_mag <= 12'h003;
        settle;
        chk({use_i, use_q}, 2'b01);
        apb(1'b0, CT_A, 32'h0);
        chk(rd[13:12], 2'b10);
        // first arrival: q first, later i ignored, new frame forgets
        apb(1'b1, RM_A, 32'h00A0_0000);
        pulse_act(1'b1, 1'b0, 1'b0);
        settle;
        chk({use_i, use_q}, 2'b11);
        pulse_act(1'b0, 1'b0, 1'b1);
        pulse_act(1'b0, 1'b1, 1'b0);
        settle;
        chk({use_i, use_q}, 2'b01);
        pulse_act(1'b1, 1'b0, 1'b0);
        pulse_act(1'b0, 1'b1, 1'b0);
        settle;
        chk({use_i, use_q}, 2'b10);
        // q right behind a frame start takes the new frame
        pulse_act(1'b1, 1'b0, 1'b1);
        settle;
        chk({use_i, use_q}, 2'b01);
        complete_run;
    end
endmodule
